// file: dv/vrc_host_checker.sv
module vrc_host_checker
   import vrc_pkg::*;
(
   input wire logic              mclk,
   input wire logic              reset_n,
   input wire logic              cmdValid,
   input wire logic              cmdReady,
   input wire logic              cmdDone,
   input wire logic              row_strobe_n,
   input wire logic              colStrobeN,
   input wire logic              lower_byte_write_n,
   input wire logic              upper_byte_write_n,
   input wire logic              output_enable_n,
   input wire logic              special_function_select,
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic [DATA_W-1:0] dqOut,
   input wire logic              dqOe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   wire wLow = !(lower_byte_write_n && upper_byte_write_n);

   sequence colFall;
      $fell(colStrobeN) && !row_strobe_n;
   endsequence
   sequence cmdTaken;
      cmdValid && cmdReady;
   endsequence

   a_read_write_high: assert property (!row_strobe_n && !colStrobeN && !output_enable_n |-> !wLow)
      else $error("write strobe low while output enabled");
   a_read_no_drive: assert property (!output_enable_n && !wLow |-> !dqOe)
      else $error("controller drives data during read");
   a_early_data: assert property (colFall ##0 wLow |-> dqOe)
      else $error("no data driven at column fall of write");
   a_late_data: assert property ($rose(wLow) && !colStrobeN && !row_strobe_n |-> dqOe && output_enable_n)
      else $error("late write without driven data");
   a_data_hold: assert property (!colStrobeN && wLow && dqOe && $past(!colStrobeN && wLow && dqOe)
      |-> $stable(dqOut))
      else $error("write data moved while latched");
   a_row_addr: assert property ($fell(row_strobe_n) |-> $stable(memAddr))
      else $error("address moved at row fall");
   a_col_addr: assert property (colFall |-> $stable(memAddr) && $stable(special_function_select))
      else $error("address or select moved at column fall");
   a_refresh_select: assert property ($fell(row_strobe_n) && !colStrobeN |-> !special_function_select && !dqOe)
      else $error("refresh with select high or data driven");
   a_busy_done: assert property (cmdTaken |=> (!cmdReady) [*4] ##[1:36] cmdDone)
      else $error("operation did not complete in time");
endmodule : vrc_host_checker

bind vrc_host vrc_host_checker vrc_host_checker_i (
   .mclk(mclk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdDone(cmdDone),
   .row_strobe_n(row_strobe_n), .colStrobeN(colStrobeN), .lower_byte_write_n(lower_byte_write_n),
   .upper_byte_write_n(upper_byte_write_n), .output_enable_n(output_enable_n),
   .special_function_select(special_function_select), .memAddr(memAddr), .dqOut(dqOut), .dqOe(dqOe));

// file: dv/vrc_host_tb.sv
module vrc_host_tb
   import vrc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic              mclk, reset_n, cmdValid, cmdReady, rdValid, cmdDone, dqOe;
   logic              row_strobe_n, colStrobeN, lower_byte_write_n, upper_byte_write_n;
   logic              output_enable_n, special_function_select;
   logic [3:0]        cmdOp;
   logic [1:0]        cmdMaskSel, cmdByteEn;
   logic [ADDR_W-1:0] cmdRow, cmdCol, memAddr;
   logic [DATA_W-1:0] cmdData, cmdBitMask, rdData, dqOut, dqIn, rdSeen;
   logic [DATA_W-1:0] cm = 16'hF00F;
   int                nMismatch = 0, testsRun = 0, cycles = 0;
   localparam logic [DATA_W-1:0] NOMASK = 16'h0000;

   vrc_host vrc_host_i (
      .mclk(mclk), .reset_n(reset_n), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
      .cmdRow(cmdRow), .cmdCol(cmdCol), .cmdData(cmdData), .cmdBitMask(cmdBitMask),
      .cmdMaskSel(cmdMaskSel), .cmdByteEn(cmdByteEn), .rdData(rdData), .rdValid(rdValid),
      .cmdDone(cmdDone), .row_strobe_n(row_strobe_n), .colStrobeN(colStrobeN),
      .lower_byte_write_n(lower_byte_write_n), .upper_byte_write_n(upper_byte_write_n),
      .output_enable_n(output_enable_n), .special_function_select(special_function_select),
      .memAddr(memAddr), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn));

   vrc_vram_model vrc_vram_model_i (
      .row_strobe_n(row_strobe_n), .colStrobeN(colStrobeN), .lower_byte_write_n(lower_byte_write_n),
      .upper_byte_write_n(upper_byte_write_n), .output_enable_n(output_enable_n),
      .special_function_select(special_function_select), .memAddr(memAddr), .dqOut(dqOut),
      .dqOe(dqOe), .dqIn(dqIn));

   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         nMismatch++;
         conclude();
      end
   end

   task automatic conclude();
      $display("mismatches %0d comparisons %0d", nMismatch, testsRun);
      if (nMismatch == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      testsRun++;
      if (seen !== exp)
      begin
         nMismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // ==========================================
   // one command, entered and left at a falling edge
   task automatic op(input logic [3:0] o, input logic [8:0] r, c, input logic [15:0] d, bm,
                     input logic [1:0] ms, be);
      cmdOp = o;
      cmdRow = r;
      cmdCol = c;
      cmdData = d;
      cmdBitMask = bm;
      cmdMaskSel = ms;
      cmdByteEn = be;
      cmdValid = 1'b1;
      rdSeen = 16'hxxxx;
      repeat (60)
      begin
         @(negedge mclk);
         cmdValid = 1'b0;
         if (rdValid === 1'b1) rdSeen = rdData;
         if (cmdDone === 1'b1) break;
      end
      check({15'h0000, cmdDone}, 16'h0001);
   endtask : op

   task automatic rdchk(input logic [8:0] r, c, input logic [15:0] exp);
      op(OP_READ, r, c, NOMASK, NOMASK, MASK_NONE, 2'h3);
      check(rdSeen, exp);
   endtask : rdchk

   // ==========================================
   // scenarios
   task automatic t_rw();
      vrc_vram_model_i.accNs = 75;
      op(OP_EARLY_WRITE, 9'h001, 9'h005, 16'hA5C3, NOMASK, MASK_NONE, 2'h3);
      rdchk(9'h001, 9'h005, 16'hA5C3);
      op(OP_LATE_WRITE, 9'h001, 9'h006, 16'h3C5A, NOMASK, MASK_NONE, 2'h3);
      rdchk(9'h001, 9'h006, 16'h3C5A);
      op(OP_RMW, 9'h001, 9'h005, 16'h0F0F, 16'h00FF, MASK_NEW, 2'h3);
      check(rdSeen, 16'hA5C3);
      rdchk(9'h001, 9'h005, 16'hA50F);
      vrc_vram_model_i.accNs = 30;
   endtask : t_rw

   task automatic t_bytes();
      op(OP_EARLY_WRITE, 9'h002, 9'h000, 16'h1111, NOMASK, MASK_NONE, 2'h3);
      op(OP_EARLY_WRITE, 9'h002, 9'h000, 16'h2222, NOMASK, MASK_NONE, 2'h1);
      rdchk(9'h002, 9'h000, 16'h1122);
      op(OP_EARLY_WRITE, 9'h002, 9'h000, 16'h3333, NOMASK, MASK_NONE, 2'h2);
      rdchk(9'h002, 9'h000, 16'h3322);
   endtask : t_bytes

   task automatic t_block();
      op(OP_LOAD_COLOR, 9'h000, 9'h000, 16'hBEEF, NOMASK, MASK_NONE, 2'h3);
      op(OP_BLOCK_WRITE, 9'h003, 9'h00D, cm, 16'h0000, MASK_NONE, 2'h3);
      for (int i = 0; i < 8; i++)
         rdchk(9'h003, 9'(8 + i), {cm[i+8] ? 8'hBE : 8'h00, cm[i] ? 8'hEF : 8'h00});
      op(OP_BLOCK_WRITE, 9'h003, 9'h017, 16'hFFFF, 16'h0FF0, MASK_NEW, 2'h1);
      rdchk(9'h003, 9'h010, 16'h00E0);
      op(OP_BLOCK_WRITE, 9'h003, 9'h010, 16'h0101, 16'h0000, MASK_NONE, 2'h2);
      rdchk(9'h003, 9'h010, 16'hBEE0);
      rdchk(9'h003, 9'h011, 16'h00E0);
   endtask : t_block

   task automatic t_persist();
      op(OP_LOAD_MASK, 9'h000, 9'h000, 16'hFF00, NOMASK, MASK_NONE, 2'h3);
      op(OP_EARLY_WRITE, 9'h004, 9'h001, 16'h1234, 16'h00FF, MASK_STORED, 2'h3);
      rdchk(9'h004, 9'h001, 16'h1200);
      op(OP_FLASH_WRITE, 9'h005, 9'h000, NOMASK, NOMASK, MASK_STORED, 2'h1);
      rdchk(9'h005, 9'h000, 16'hBE00);
      rdchk(9'h005, 9'h1FF, 16'hBE00);
      op(OP_REFRESH_RESET, 9'h000, 9'h000, NOMASK, NOMASK, MASK_NONE, 2'h3);
      op(OP_EARLY_WRITE, 9'h004, 9'h001, 16'h5678, 16'h000F, MASK_NEW, 2'h3);
      rdchk(9'h004, 9'h001, 16'h1208);
      op(OP_FLASH_WRITE, 9'h006, 9'h000, NOMASK, NOMASK, MASK_NONE, 2'h2);
      rdchk(9'h006, 9'h100, 16'hBEEF);
   endtask : t_persist

   initial
   begin
      reset_n = 1'b0;
      cmdValid = 1'b0;
      cmdOp = OP_READ;
      cmdRow = 9'h000;
      cmdCol = 9'h000;
      cmdData = NOMASK;
      cmdBitMask = NOMASK;
      cmdMaskSel = MASK_NONE;
      cmdByteEn = 2'h3;
      repeat (6) @(posedge mclk);
      @(negedge mclk);
      reset_n = 1'b1;
      t_rw();
      t_bytes();
      t_block();
      t_persist();
      conclude();
   end
endmodule : vrc_host_tb

// file: dv/vrc_vram_model.sv
module vrc_vram_model
   import vrc_pkg::*;
(
   input  wire logic              row_strobe_n,
   input  wire logic              colStrobeN,
   input  wire logic              lower_byte_write_n,
   input  wire logic              upper_byte_write_n,
   input  wire logic              output_enable_n,
   input  wire logic              special_function_select,
   input  wire logic [ADDR_W-1:0] memAddr,
   input  wire logic [DATA_W-1:0] dqOut,
   input  wire logic              dqOe,
   output logic      [DATA_W-1:0] dqIn
);
   timeunit 1ns;
   timeprecision 100ps;
   // ==========================================
   // storage and latched cycle state
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] maskReg_r = 16'h0000, colorReg_r = 16'h0000, rowMask_r, colDq_r, rdVal_r;
   logic [DATA_W-1:0] lastVal_r = 16'h0000;
   logic [ADDR_W-1:0] row_r, col_r;
   logic              maskLoaded_r = 1'b0, rowSf_r = 1'b0, colSf_r, colSeen_r = 1'b0;
   logic              wrDone_r = 1'b1, rdOn_r = 1'b0;
   int                accNs = 30;
   wire               wLow = !(lower_byte_write_n && upper_byte_write_n);
   wire  [DATA_W-1:0] lane = {{8{!upper_byte_write_n}}, {8{!lower_byte_write_n}}};

   // released pins show the inverse of the last driven value
   assign dqIn = dqOe ? dqOut : (rdOn_r ? rdVal_r : ~lastVal_r);

   always @(dqOe, dqOut, rdOn_r, rdVal_r)
      if (dqOe) lastVal_r = dqOut;
      else if (rdOn_r) lastVal_r = rdVal_r;

   function automatic logic [DATA_W-1:0] peek(input logic [17:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : 16'h0000;
   endfunction : peek

   function automatic void put(input logic [17:0] a, input logic [15:0] d, input logic [15:0] m);
      mem[int'(a)] = (peek(a) & ~m) | (d & m);
   endfunction : put

   // ==========================================
   // writes land on the later of column and write fall
   task automatic doWrite();
      if (row_strobe_n || colStrobeN || !wLow || wrDone_r || rowSf_r || !colSeen_r) return;
      wrDone_r = 1'b1;
      if (colSf_r)
         for (int i = 0; i < 8; i++)
            put({row_r, col_r[8:3], 3'(i)}, colorReg_r, rowMask_r & lane & {{8{colDq_r[i+8]}}, {8{colDq_r[i]}}});
      else
         put({row_r, col_r}, dqIn, rowMask_r & lane);
   endtask : doWrite

   always @(negedge row_strobe_n)
   begin
      row_r = memAddr;
      rowSf_r = special_function_select;
      colSeen_r = 1'b0;
      if (!colStrobeN) rowSf_r = 1'b0;
      if (!colStrobeN && !special_function_select) maskLoaded_r = 1'b0;
      else if (!wLow) rowMask_r = 16'hFFFF;
      else if (maskLoaded_r) rowMask_r = maskReg_r;
      else rowMask_r = dqIn;
   end

   always @(negedge colStrobeN)
   begin
      if (!row_strobe_n)
      begin
         colSeen_r = 1'b1;
         wrDone_r = 1'b0;
         colSf_r = special_function_select;
         col_r = memAddr;
         colDq_r = dqIn;
         if (rowSf_r && colSf_r) colorReg_r = (colorReg_r & ~lane) | (dqIn & lane);
         if (rowSf_r && !colSf_r) maskReg_r = (maskReg_r & ~lane) | (dqIn & lane);
         if (rowSf_r && !colSf_r) maskLoaded_r = 1'b1;
         doWrite();
      end
   end

   // both strobes may fall in one step: let them settle
   always @(negedge lower_byte_write_n or negedge upper_byte_write_n)
   begin
      #1;
      doWrite();
   end

   always @(posedge row_strobe_n)
   begin
      if (rowSf_r && !colSeen_r)
         for (int c = 0; c < 512; c++)
            put({row_r, 9'(c)}, colorReg_r, rowMask_r);
      rowSf_r = 1'b0;
   end

   // fast-page output: drives only while column and enable are low
   always @(row_strobe_n, colStrobeN, output_enable_n, wLow)
   begin
      rdOn_r = 1'b0;
      if (!row_strobe_n && !colStrobeN && !output_enable_n && !wLow)
      begin
         rdVal_r = peek({row_r, memAddr});
         #(accNs) rdOn_r = !row_strobe_n && !colStrobeN && !output_enable_n;
      end
   end
endmodule : vrc_vram_model

// file: include/vrc_pkg.sv
package vrc_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 9;
   localparam int DATA_W = 16;

   // ==========================================================
   // host operations
   localparam logic [3:0] OP_READ          = 4'h0;
   localparam logic [3:0] OP_EARLY_WRITE   = 4'h1;
   localparam logic [3:0] OP_LATE_WRITE    = 4'h2;
   localparam logic [3:0] OP_RMW           = 4'h3;
   localparam logic [3:0] OP_LOAD_MASK     = 4'h4;
   localparam logic [3:0] OP_LOAD_COLOR    = 4'h5;
   localparam logic [3:0] OP_BLOCK_WRITE   = 4'h6;
   localparam logic [3:0] OP_FLASH_WRITE   = 4'h7;
   localparam logic [3:0] OP_REFRESH_RESET = 4'h8;

   // ==========================================================
   // bit mask selection at row strobe fall
   localparam logic [1:0] MASK_NONE   = 2'h0;
   localparam logic [1:0] MASK_NEW    = 2'h1;
   localparam logic [1:0] MASK_STORED = 2'h2;

   // ==========================================================
   // cycle decode on the special function pin
   localparam logic SF_ROW_LOAD   = 1'b1;
   localparam logic SF_ROW_NORMAL = 1'b0;
   localparam logic SF_COL_BLOCK  = 1'b1;
   localparam logic SF_COL_COLOR  = 1'b1;
   localparam logic SF_COL_NORMAL = 1'b0;
   localparam logic [8:0] BLOCK_ALIGN_MASK = 9'h1f8;

   // ==========================================================
   // reset values of pins
   localparam logic [15:0] DQ_RESET   = 16'h0000;
   localparam logic [8:0]  ADDR_RESET = 9'h000;

   // ==========================================================
   // timing at 25 MHz
   localparam int CLK_MHZ         = 25;
   localparam int T_SETUP_NS      = 40;
   localparam int T_ACCESS_NS     = 80;
   localparam int T_PRECHARGE_NS  = 60;
   localparam int SYNC_CYC        = 3;
   localparam int SETUP_CYC       = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int ACCESS_CYC      = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int PRECHARGE_CYC   = (T_PRECHARGE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0] CNT_SETUP = 4'(SETUP_CYC);
   localparam logic [3:0] CNT_READ  = 4'(ACCESS_CYC + SYNC_CYC);
   localparam logic [3:0] CNT_PRE   = 4'(PRECHARGE_CYC);

   // ==========================================================
   // sequencer states
   typedef enum logic [7:0] {
      ST_IDLE    = 8'b0000_0001,
      ST_ROWSET  = 8'b0000_0010,
      ST_ROWHOLD = 8'b0000_0100,
      ST_COLSET  = 8'b0000_1000,
      ST_COL     = 8'b0001_0000,
      ST_LATE    = 8'b0010_0000,
      ST_END     = 8'b0100_0000,
      ST_PRE     = 8'b1000_0000
   } vrc_state_t;

endpackage : vrc_pkg

// file: logic/vrc_host.sv
// Operation
// - read: row, column, output enable; write high
// - early write: write low before column
// - late write: write falls after column
// - write low at row latches one-cycle mask, or uses the stored mask while one is loaded
// - read-modify-write: read, disable output, write
// - unmasked block write: both writes high at row fall
module vrc_host
   import vrc_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               reset_n,
   // user command port
   input  wire logic               cmdValid,
   output logic                    cmdReady,
   input  wire logic [3:0]         cmdOp,
   input  wire logic [ADDR_W-1:0]  cmdRow,
   input  wire logic [ADDR_W-1:0]  cmdCol,
   input  wire logic [DATA_W-1:0]  cmdData,
   input  wire logic [DATA_W-1:0]  cmdBitMask,
   input  wire logic [1:0]         cmdMaskSel,
   input  wire logic [1:0]         cmdByteEn,
   output logic [DATA_W-1:0]       rdData,
   output logic                    rdValid,
   output logic                    cmdDone,
   // device pins
   output logic                    row_strobe_n,
   output logic                    colStrobeN,
   output logic                    lower_byte_write_n,
   output logic                    upper_byte_write_n,
   output logic                    output_enable_n,
   output logic                    special_function_select,
   output logic [ADDR_W-1:0]       memAddr,
   output logic [DATA_W-1:0]       dqOut,
   output logic                    dqOe,
   input  wire logic [DATA_W-1:0]  dqIn
);

   // ==========================================================
   // state
   vrc_state_t        state_r;
   vrc_state_t        state_nxt;
   logic [3:0]        cnt_r;
   logic [3:0]        cnt_nxt;
   logic [3:0]        op_r;
   logic [ADDR_W-1:0] col_r;
   logic [DATA_W-1:0] data_r;
   logic [1:0]        byteEn_r;
   logic              reN_nxt;
   logic              ceN_nxt;
   logic              lwN_nxt;
   logic              uwN_nxt;
   logic              oeN_nxt;
   logic              sf_nxt;
   logic [ADDR_W-1:0] addr_nxt;
   logic [DATA_W-1:0] dq_nxt;
   logic              dqOe_nxt;
   logic              rdValid_nxt;
   logic              done_nxt;
   logic [DATA_W-1:0] dqSync;

   vrc_sync3 #(.W(DATA_W)) u_dq_sync (
      .mclk    (mclk),
      .reset_n (reset_n),
      .din     (dqIn),
      .dout    (dqSync)
   );

   // ==========================================================
   // command decode
   wire accept      = (state_r == ST_IDLE) && cmdValid;
   wire timerDone   = (cnt_r == 4'h0);
   wire isRead      = (op_r == OP_READ) || (op_r == OP_RMW);
   wire isLate      = (op_r == OP_LATE_WRITE) || (op_r == OP_RMW);
   wire isBlock     = (op_r == OP_BLOCK_WRITE);
   wire isFlash     = (op_r == OP_FLASH_WRITE);
   wire isRefresh   = (op_r == OP_REFRESH_RESET);
   wire noColumn    = isFlash || isRefresh;
   wire cmdMasked   = (cmdMaskSel != MASK_NONE);
   wire cmdMaskable = (cmdOp == OP_EARLY_WRITE) || (cmdOp == OP_LATE_WRITE) || (cmdOp == OP_RMW)
                      || (cmdOp == OP_BLOCK_WRITE) || (cmdOp == OP_FLASH_WRITE);
   // write low at row fall only for masked writes; unmasked block keeps both high
   wire wLowAtRow   = cmdMaskable && cmdMasked;
   wire driveMask   = wLowAtRow && (cmdMaskSel == MASK_NEW);
   wire cmdRowSf    = ((cmdOp == OP_LOAD_MASK) || (cmdOp == OP_LOAD_COLOR) || (cmdOp == OP_FLASH_WRITE))
                      ? SF_ROW_LOAD : SF_ROW_NORMAL;
   wire colSf       = isBlock ? SF_COL_BLOCK :
                      (op_r == OP_LOAD_COLOR) ? SF_COL_COLOR : SF_COL_NORMAL;
   // block write: pins carry column byte mask, address aligned to eight columns
   wire [ADDR_W-1:0] colAddr = isBlock ? (col_r & BLOCK_ALIGN_MASK) : col_r;
   wire earlyW      = !isRead && !isLate;
   wire lowW        = byteEn_r[0];
   wire upW         = byteEn_r[1];

   // ==========================================================
   // sequencer
   always_comb
   begin
      state_nxt   = state_r;
      cnt_nxt     = timerDone ? cnt_r : cnt_r - 4'h1;
      reN_nxt     = row_strobe_n;
      ceN_nxt     = colStrobeN;
      lwN_nxt     = lower_byte_write_n;
      uwN_nxt     = upper_byte_write_n;
      oeN_nxt     = output_enable_n;
      sf_nxt      = special_function_select;
      addr_nxt    = memAddr;
      dq_nxt      = dqOut;
      dqOe_nxt    = dqOe;
      rdValid_nxt = 1'b0;
      done_nxt    = 1'b0;
      unique case (state_r)
         ST_IDLE:
         begin
            if (accept)
            begin
               state_nxt = ST_ROWSET;
               cnt_nxt   = CNT_SETUP;
               addr_nxt  = cmdRow;
               sf_nxt    = cmdRowSf;
               // flash masks both bytes together
               lwN_nxt   = !wLowAtRow;
               uwN_nxt   = !wLowAtRow;
               dq_nxt    = driveMask ? cmdBitMask : DQ_RESET;
               dqOe_nxt  = driveMask;
               // column strobe before row strobe with select low
               ceN_nxt   = (cmdOp != OP_REFRESH_RESET);
               if (cmdOp == OP_REFRESH_RESET)
                  sf_nxt = 1'b0;
            end
         end
         ST_ROWSET:
         begin
            if (timerDone)
            begin
               state_nxt = ST_ROWHOLD;
               cnt_nxt   = CNT_SETUP;
               reN_nxt   = 1'b0;
            end
         end
         ST_ROWHOLD:
         begin
            if (timerDone)
            begin
               lwN_nxt  = 1'b1;
               uwN_nxt  = 1'b1;
               dqOe_nxt = 1'b0;
               sf_nxt   = 1'b0;
               if (noColumn)
               begin
                  state_nxt = ST_END;
                  cnt_nxt   = CNT_READ;
               end
               else
               begin
                  state_nxt = ST_COLSET;
                  cnt_nxt   = CNT_SETUP;
                  addr_nxt  = colAddr;
                  sf_nxt    = colSf;
                  if (earlyW)
                  begin
                     lwN_nxt  = !lowW;
                     uwN_nxt  = !upW;
                     dq_nxt   = data_r;
                     dqOe_nxt = 1'b1;
                  end
               end
            end
         end
         ST_COLSET:
         begin
            if (timerDone)
            begin
               state_nxt = ST_COL;
               cnt_nxt   = isRead ? CNT_READ : CNT_SETUP;
               ceN_nxt   = 1'b0;
               oeN_nxt   = !isRead;
            end
         end
         ST_COL:
         begin
            if (timerDone)
            begin
               if (op_r == OP_READ || op_r == OP_RMW)
               begin
                  rdValid_nxt = 1'b1;
               end
               if (isLate)
               begin
                  state_nxt = ST_LATE;
                  cnt_nxt   = CNT_SETUP;
                  oeN_nxt   = 1'b1;
                  dq_nxt    = data_r;
                  dqOe_nxt  = 1'b1;
               end
               else
               begin
                  state_nxt = ST_END;
                  cnt_nxt   = CNT_SETUP;
               end
            end
         end
         ST_LATE:
         begin
            if (timerDone)
            begin
               state_nxt = ST_END;
               cnt_nxt   = CNT_SETUP;
               lwN_nxt   = !lowW;
               uwN_nxt   = !upW;
            end
         end
         ST_END:
         begin
            if (timerDone)
            begin
               state_nxt = ST_PRE;
               cnt_nxt   = CNT_PRE;
               reN_nxt   = 1'b1;
               ceN_nxt   = 1'b1;
               lwN_nxt   = 1'b1;
               uwN_nxt   = 1'b1;
               oeN_nxt   = 1'b1;
               sf_nxt    = 1'b0;
               dqOe_nxt  = 1'b0;
            end
         end
         ST_PRE:
         begin
            if (timerDone)
            begin
               state_nxt = ST_IDLE;
               done_nxt  = 1'b1;
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r                 <= ST_IDLE;
         cnt_r                   <= 4'h0;
         row_strobe_n            <= 1'b1;
         colStrobeN              <= 1'b1;
         lower_byte_write_n      <= 1'b1;
         upper_byte_write_n      <= 1'b1;
         output_enable_n         <= 1'b1;
         special_function_select <= 1'b0;
         memAddr                 <= ADDR_RESET;
         dqOut                   <= DQ_RESET;
         dqOe                    <= 1'b0;
         rdValid                 <= 1'b0;
         cmdDone                 <= 1'b0;
         cmdReady                <= 1'b1;
      end
      else
      begin
         state_r                 <= state_nxt;
         cnt_r                   <= cnt_nxt;
         row_strobe_n            <= reN_nxt;
         colStrobeN              <= ceN_nxt;
         lower_byte_write_n      <= lwN_nxt;
         upper_byte_write_n      <= uwN_nxt;
         output_enable_n         <= oeN_nxt;
         special_function_select <= sf_nxt;
         memAddr                 <= addr_nxt;
         dqOut                   <= dq_nxt;
         dqOe                    <= dqOe_nxt;
         rdValid                 <= rdValid_nxt;
         cmdDone                 <= done_nxt;
         cmdReady                <= (state_nxt == ST_IDLE);
      end
   end

   // ==========================================================
   // command capture and read data
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         op_r      <= OP_READ;
         col_r     <= ADDR_RESET;
         data_r    <= DQ_RESET;
         byteEn_r  <= 2'h0;
         rdData    <= DQ_RESET;
      end
      else
      begin
         if (accept)
         begin
            op_r      <= cmdOp;
            col_r     <= cmdCol;
            data_r    <= cmdData;
            byteEn_r  <= cmdByteEn;
         end
         if (rdValid_nxt)
            rdData <= dqSync;
      end
   end

endmodule : vrc_host

// file: logic/vrc_sync3.sv
module vrc_sync3 #(
   parameter int W = 16
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);

   // ==========================================================
   // three stages; a value counts once stages two and three agree
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   wire          stable = (s2_r == s3_r);

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         dout <= '0;
      end
      else
      begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (stable)
            dout <= s3_r;
      end
   end

endmodule : vrc_sync3
